// ==== cic_defines.vh ====
// constants for the cascaded interrupt controller pair
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH

// i/o addresses
`define CIC_MASTER_EVEN 8'h20
`define CIC_MASTER_ODD 8'h21
`define CIC_SLAVE_EVEN 8'hA0
`define CIC_SLAVE_ODD 8'hA1

// command word bit positions
`define CIC_INIT_BIT 4
`define CIC_OP_WORD_THREE_BIT 3
`define CIC_INIT_WORD_ONE_SINGLE_BIT 1
`define CIC_INIT_WORD_ONE_NEED4_BIT 0
`define CIC_ICW4_AUTO_SERVICE_DONE_BIT 1
`define CIC_OP_WORD_THREE_RR_BIT 1
`define CIC_OP_WORD_THREE_RIS_BIT 0

// end-of-interrupt command codes in data bits 7..5
`define CIC_EOI_NONSPEC 3'h1
`define CIC_EOI_SPEC 3'h3
// special mask mode field in data bits 6..5
`define CIC_SMM_SET 2'h3
`define CIC_SMM_CLR 2'h2

// master channel that carries the slave, reset slave identity and spurious vector channel
`define CIC_CASCADE_CH 2
`define CIC_SLAVE_ID_RST 3'h7
`define CIC_SPURIOUS_CH 3'h7

`endif

// ==== cic_top.v ====
// cascaded pair of eight-channel interrupt controllers with i/o and acknowledge logic
`default_nettype none
`include "cic_defines.vh"

// ---------------------------------------------------------------
// one eight-channel controller
// ---------------------------------------------------------------
module cic_ctrl #(
	parameter IS_MASTER = 1
) (
	// clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// command writes
	input wire wr_even_i,
	input wire wr_odd_i,
	input wire [7:0] wdata_i,
	// acknowledge cycles
	input wire ack_first_i,
	input wire ack_second_i,
	input wire casc_valid_i,
	input wire [2:0] casc_code_i,
	// requests
	input wire [7:0] channel_request_inputs_i,
	// results
	output wire cpu_irq_out_o,
	output wire casc_active_o,
	output wire [2:0] casc_code_o,
	output wire owner_o,
	output wire [7:0] vector_o,
	output wire [7:0] even_rd_o,
	output wire [7:0] odd_rd_o
);
	localparam ST_READY = 2'h0;
	localparam ST_INIT_WORD_TWO = 2'h1;
	localparam ST_ICW3 = 2'h2;
	localparam ST_ICW4 = 2'h3;

	reg [7:0] pending_request_latch_r, pending_request_latch_nxt;
	reg [7:0] in_service_bits_r, in_service_bits_nxt;
	reg [7:0] channel_mask_bits_r;
	reg [7:0] req_prev_r;
	reg [1:0] state_r;
	reg [4:0] vec_base_r;
	reg [7:0] casc_map_r;
	reg [2:0] slave_id_r;
	reg single_r, need4_r, auto_service_done_r, smm_r, rd_isr_r;
	reg [7:0] vec_r;
	reg [2:0] ack_ch_r;
	reg ack_vld_r, owner_r;

	reg found, blocked, is_found;
	reg [2:0] req_ch, is_ch;
	integer i;

	wire act_first;
	wire op_word_two_wr;
	wire [7:0] req_rise;

	// ---------------------------------------------------------------
	// priority resolution
	// ---------------------------------------------------------------
	// channel 0 first; a set service bit stops the search at its level unless it is masked under special mask mode
	always @* begin
		found = 1'b0;
		blocked = 1'b0;
		req_ch = 3'h0;
		is_found = 1'b0;
		is_ch = 3'h0;
		for (i = 0; i < 8; i = i + 1) begin
			if (!found && !blocked) begin
				if (in_service_bits_r[i] && !(smm_r && channel_mask_bits_r[i])) begin
					blocked = 1'b1;
				end else if (pending_request_latch_r[i] && !channel_mask_bits_r[i]) begin
					found = 1'b1;
					req_ch = i[2:0];
				end
			end
			// masked service bits are skipped under special mask mode
			if (!is_found && in_service_bits_r[i] && !(smm_r && channel_mask_bits_r[i])) begin
				is_found = 1'b1;
				is_ch = i[2:0];
			end
		end
	end

	assign cpu_irq_out_o = found;
	assign casc_active_o = (IS_MASTER != 0) && found && !single_r && casc_map_r[req_ch];
	assign casc_code_o = req_ch;
	// the slave answers only when the master's code equals its identity
	assign act_first = ack_first_i &&
		((IS_MASTER != 0) || (casc_valid_i && (casc_code_i == slave_id_r)));
	assign op_word_two_wr = wr_even_i && !wdata_i[`CIC_INIT_BIT] && !wdata_i[`CIC_OP_WORD_THREE_BIT];
	assign req_rise = channel_request_inputs_i & ~req_prev_r;

	// ---------------------------------------------------------------
	// request and service bits
	// ---------------------------------------------------------------
	always @* begin
		pending_request_latch_nxt = pending_request_latch_r & channel_request_inputs_i;
		in_service_bits_nxt = in_service_bits_r;
		if (act_first && found) begin
			pending_request_latch_nxt[req_ch] = 1'b0;
		end
		// a new edge in the acknowledge cycle is kept
		pending_request_latch_nxt = pending_request_latch_nxt | req_rise;
		if (ack_second_i && ack_vld_r && auto_service_done_r) begin
			in_service_bits_nxt[ack_ch_r] = 1'b0;
		end
		if (op_word_two_wr) begin
			if (wdata_i[7:5] == `CIC_EOI_SPEC) begin
				in_service_bits_nxt[wdata_i[2:0]] = 1'b0;
			end else if (wdata_i[7:5] == `CIC_EOI_NONSPEC && is_found) begin
				in_service_bits_nxt[is_ch] = 1'b0;
			end
		end
		// set last: an acknowledge wins over a clear in the same cycle
		if (act_first && found) begin
			in_service_bits_nxt[req_ch] = 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			pending_request_latch_r <= 8'h00;
			in_service_bits_r <= 8'h00;
			req_prev_r <= 8'h00;
		end else begin
			pending_request_latch_r <= pending_request_latch_nxt;
			in_service_bits_r <= in_service_bits_nxt;
			req_prev_r <= channel_request_inputs_i;
		end
	end

	// ---------------------------------------------------------------
	// command words
	// ---------------------------------------------------------------
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_r <= ST_READY;
			channel_mask_bits_r <= 8'h00;
			vec_base_r <= 5'h00;
			casc_map_r <= 8'h00;
			slave_id_r <= `CIC_SLAVE_ID_RST;
			single_r <= 1'b0;
			need4_r <= 1'b0;
			auto_service_done_r <= 1'b0;
			smm_r <= 1'b0;
			rd_isr_r <= 1'b0;
		end else if (wr_even_i && wdata_i[`CIC_INIT_BIT]) begin
			state_r <= ST_INIT_WORD_TWO;
			channel_mask_bits_r <= 8'h00;
			rd_isr_r <= 1'b0;
			smm_r <= 1'b0;
			slave_id_r <= `CIC_SLAVE_ID_RST;
			single_r <= wdata_i[`CIC_INIT_WORD_ONE_SINGLE_BIT];
			need4_r <= wdata_i[`CIC_INIT_WORD_ONE_NEED4_BIT];
			auto_service_done_r <= 1'b0;
		end else if (wr_even_i) begin
			// an operation word also ends an unfinished init sequence
			state_r <= ST_READY;
			if (wdata_i[`CIC_OP_WORD_THREE_BIT]) begin
				if (wdata_i[`CIC_OP_WORD_THREE_RR_BIT]) begin
					rd_isr_r <= wdata_i[`CIC_OP_WORD_THREE_RIS_BIT];
				end
				if (wdata_i[6:5] == `CIC_SMM_SET) begin
					smm_r <= 1'b1;
				end else if (wdata_i[6:5] == `CIC_SMM_CLR) begin
					smm_r <= 1'b0;
				end
			end
		end else if (wr_odd_i) begin
			case (state_r)
				ST_READY: begin
					channel_mask_bits_r <= wdata_i;
				end
				ST_INIT_WORD_TWO: begin
					vec_base_r <= wdata_i[7:3];
					state_r <= !single_r ? ST_ICW3 : (need4_r ? ST_ICW4 : ST_READY);
				end
				ST_ICW3: begin
					casc_map_r <= wdata_i;
					slave_id_r <= wdata_i[2:0];
					state_r <= need4_r ? ST_ICW4 : ST_READY;
				end
				ST_ICW4: begin
					auto_service_done_r <= wdata_i[`CIC_ICW4_AUTO_SERVICE_DONE_BIT];
					state_r <= ST_READY;
				end
				default: begin
					state_r <= ST_READY;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// acknowledge capture
	// ---------------------------------------------------------------
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			vec_r <= 8'h00;
			ack_ch_r <= 3'h0;
			ack_vld_r <= 1'b0;
			owner_r <= 1'b0;
		end else if (ack_first_i) begin
			ack_vld_r <= act_first && found;
			ack_ch_r <= req_ch;
			// vector waits in a flop for the second cycle
			if (act_first && found) begin
				vec_r <= {vec_base_r, req_ch};
			end else begin
				vec_r <= {vec_base_r, `CIC_SPURIOUS_CH};
			end
			owner_r <= act_first && !casc_active_o;
		end
	end

	assign owner_o = owner_r;
	assign vector_o = vec_r;
	assign even_rd_o = rd_isr_r ? in_service_bits_r : pending_request_latch_r;
	assign odd_rd_o = channel_mask_bits_r;
endmodule // cic_ctrl

// ---------------------------------------------------------------
// top: master, slave, i/o decode and acknowledge counting
// ---------------------------------------------------------------
module cic_top (
	// clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// register port
	input wire [7:0] addr_i,
	input wire [7:0] wr_data_i,
	input wire wr_stb_i,
	input wire rd_stb_i,
	output wire [7:0] rd_data_o,
	// request sources
	input wire timer_zero_output_i,
	input wire rtc_irq_i,
	input wire [7:0] master_irq_pins_i,
	input wire [7:0] slave_irq_pins_i,
	// processor side
	input wire irq_ack_cycle_i,
	output wire cpu_irq_out_o,
	output wire [7:0] peripheral_data_bus_o,
	output wire peripheral_data_oe_n_o
);
	reg ack_phase_r;
	reg [7:0] rd_data_r;

	wire ack_first, ack_second;
	wire slave_irq, m_casc, s_casc_unused, m_owner, s_owner;
	wire [2:0] m_code, s_code_unused;
	wire [7:0] m_vec, s_vec, m_even, m_odd, s_even, s_odd;
	wire [7:0] m_req, s_req;
	wire m_we, m_wo, s_we, s_wo;

	// ---------------------------------------------------------------
	// decode and wiring
	// ---------------------------------------------------------------
	assign m_we = wr_stb_i && (addr_i == `CIC_MASTER_EVEN);
	assign m_wo = wr_stb_i && (addr_i == `CIC_MASTER_ODD);
	assign s_we = wr_stb_i && (addr_i == `CIC_SLAVE_EVEN);
	assign s_wo = wr_stb_i && (addr_i == `CIC_SLAVE_ODD);

	// pins on channels with an internal source are not used
	assign m_req = {master_irq_pins_i[7:3], slave_irq, master_irq_pins_i[1],
		timer_zero_output_i};
	assign s_req = {slave_irq_pins_i[7:1], rtc_irq_i};

	// one strobe per acknowledge cycle; the phase flips on every acknowledge cycle
	assign ack_first = irq_ack_cycle_i && !ack_phase_r;
	assign ack_second = irq_ack_cycle_i && ack_phase_r;

	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			ack_phase_r <= 1'b0;
			rd_data_r <= 8'h00;
		end else begin
			if (irq_ack_cycle_i) begin
				ack_phase_r <= !ack_phase_r;
			end
			if (rd_stb_i) begin
				case (addr_i)
					`CIC_MASTER_EVEN: rd_data_r <= m_even;
					`CIC_MASTER_ODD: rd_data_r <= m_odd;
					`CIC_SLAVE_EVEN: rd_data_r <= s_even;
					`CIC_SLAVE_ODD: rd_data_r <= s_odd;
					default: rd_data_r <= 8'h00;
				endcase
			end else begin
				rd_data_r <= 8'h00;
			end
		end
	end

	assign rd_data_o = rd_data_r;
	// a cascaded master leaves the vector to the slave
	assign peripheral_data_bus_o = m_owner ? m_vec : (s_owner ? s_vec : m_vec);
	assign peripheral_data_oe_n_o = !ack_second;

	// ---------------------------------------------------------------
	// controllers
	// ---------------------------------------------------------------
	cic_ctrl #(.IS_MASTER(1)) u_master_irq_ctrl (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.wr_even_i(m_we),
		.wr_odd_i(m_wo),
		.wdata_i(wr_data_i),
		.ack_first_i(ack_first),
		.ack_second_i(ack_second),
		.casc_valid_i(1'b0),
		.casc_code_i(3'h0),
		.channel_request_inputs_i(m_req),
		.cpu_irq_out_o(cpu_irq_out_o),
		.casc_active_o(m_casc),
		.casc_code_o(m_code),
		.owner_o(m_owner),
		.vector_o(m_vec),
		.even_rd_o(m_even),
		.odd_rd_o(m_odd)
	);

	cic_ctrl #(.IS_MASTER(0)) u_slave_irq_ctrl (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.wr_even_i(s_we),
		.wr_odd_i(s_wo),
		.wdata_i(wr_data_i),
		.ack_first_i(ack_first),
		.ack_second_i(ack_second),
		.casc_valid_i(m_casc),
		.casc_code_i(m_code),
		.channel_request_inputs_i(s_req),
		.cpu_irq_out_o(slave_irq),
		.casc_active_o(s_casc_unused),
		.casc_code_o(s_code_unused),
		.owner_o(s_owner),
		.vector_o(s_vec),
		.even_rd_o(s_even),
		.odd_rd_o(s_odd)
	);
endmodule // cic_top

`default_nettype wire

// ==== cic_top_notes_end.v ====
// intentionally empty companion file
`default_nettype none
`default_nettype wire

// ==== cic_props.sv ====
// assertion checker for the cascaded interrupt controller pair
`default_nettype none
module cic_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic rd_stb_i,
	input wire logic [7:0] rd_data_o,
	// request sources
	input wire logic timer_zero_output_i,
	input wire logic rtc_irq_i,
	input wire logic [7:0] master_irq_pins_i,
	input wire logic [7:0] slave_irq_pins_i,
	// processor side
	input wire logic irq_ack_cycle_i,
	input wire logic cpu_irq_out_o,
	input wire logic [7:0] peripheral_data_bus_o,
	input wire logic peripheral_data_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic second_r;
	wire any_src;
	// ------
	// pairing of acknowledge pulses
	// ------
	// the checker keeps its own count so a stuck design counter is seen
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) second_r <= 1'b0;
		else if (irq_ack_cycle_i) second_r <= !second_r;
	end
	assign any_src = timer_zero_output_i | rtc_irq_i | (|master_irq_pins_i) | (|slave_irq_pins_i);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_first;
		irq_ack_cycle_i && !second_r;
	endsequence
	sequence s_second;
		irq_ack_cycle_i && second_r;
	endsequence
	a_oe_on_second: assert property (s_second |-> !peripheral_data_oe_n_o)
		else $error("bus not driven on second acknowledge");
	a_oe_off_else: assert property (!(irq_ack_cycle_i && second_r) |-> peripheral_data_oe_n_o)
		else $error("bus driven outside second acknowledge");
	a_spur_level_seven: assert property (s_first ##0 !cpu_irq_out_o |=>
		peripheral_data_bus_o[2:0] == 3'h7) else $error("spurious vector not level seven");
	a_vector_holds: assert property (!(irq_ack_cycle_i && !second_r) |=>
		$stable(peripheral_data_bus_o)) else $error("vector changed between acknowledges");
	a_rd_has_cause: assert property (rd_data_o != 8'h00 |-> $past(rd_stb_i))
		else $error("read data without read strobe");
	a_unmapped_zero: assert property ($past(rd_stb_i) &&
		!($past(addr_i) inside {8'h20, 8'h21, 8'hA0, 8'hA1}) |-> rd_data_o == 8'h00)
		else $error("unmapped read returned data");
	a_reset_quiet: assert property ($rose(reset_n_i) |-> !cpu_irq_out_o &&
		peripheral_data_oe_n_o && rd_data_o == 8'h00) else $error("outputs busy after reset");
	a_irq_has_source: assert property (cpu_irq_out_o |-> any_src ||
		$past(any_src) || $past(any_src, 2)) else $error("interrupt without request");
endmodule // cic_props
`default_nettype wire

// ==== cic_cpu_model.sv ====
// processor model answering the interrupt line with acknowledge pairs
`default_nettype none
module cic_cpu_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// bench control
	input wire logic spur_i,
	input wire logic slow_i,
	// controller side
	input wire logic irq_i,
	input wire logic [7:0] bus_i,
	input wire logic oe_n_i,
	output logic ack_o,
	// captured vector
	output logic [7:0] vec_o,
	output logic vec_valid_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ack_o = 1'b0;
		vec_o = 8'h00;
		vec_valid_o = 1'b0;
		forever begin
			@(posedge clk_i);
			vec_valid_o <= 1'b0;
			if (reset_n_i && (irq_i || spur_i)) begin
				ack_o <= 1'b1;
				@(posedge clk_i);
				ack_o <= 1'b0;
				repeat (slow_i ? 3 : 1) @(posedge clk_i);
				ack_o <= 1'b1;
				@(posedge clk_i);
				ack_o <= 1'b0;
				// an undriven bus reads as unknown so it can match no announced vector
				vec_o <= oe_n_i ? 8'hXX : bus_i;
				vec_valid_o <= 1'b1;
			end
		end
	end
endmodule // cic_cpu_model
`default_nettype wire

// ==== cic_tb.sv ====
// self-checking bench for the cascaded interrupt controller pair
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, reset_n_i, wr_stb_i, rd_stb_i, timer_zero_output_i, rtc_irq_i, spur, slow;
	logic [7:0] addr_i, wr_data_i, rd_data_o, master_irq_pins_i, slave_irq_pins_i, vec, bm, bs;
	logic [7:0] peripheral_data_bus_o;
	logic irq_ack_cycle_i, cpu_irq_out_o, peripheral_data_oe_n_o, vec_valid;
	logic rd_pend = 1'b0;
	logic [7:0] rq[$], vq[$];
	int err_count = 0, n_compared = 0;
	cic_top dut (.clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_stb_i, .rd_stb_i, .rd_data_o,
		.timer_zero_output_i, .rtc_irq_i, .master_irq_pins_i, .slave_irq_pins_i,
		.irq_ack_cycle_i, .cpu_irq_out_o, .peripheral_data_bus_o, .peripheral_data_oe_n_o);
	cic_cpu_model cpu (.clk_i, .reset_n_i, .spur_i(spur), .slow_i(slow), .irq_i(cpu_irq_out_o),
		.bus_i(peripheral_data_bus_o), .oe_n_i(peripheral_data_oe_n_o),
		.ack_o(irq_ack_cycle_i), .vec_o(vec), .vec_valid_o(vec_valid));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ------
	// register port and request drivers
	// ------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_stb_i <= 1'b1;
		@(posedge clk_i);
		wr_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		@(posedge clk_i);
		addr_i <= a;
		rd_stb_i <= 1'b1;
		@(posedge clk_i);
		rd_stb_i <= 1'b0;
	endtask
	task automatic pins(input logic [7:0] m, input logic [7:0] s, input logic t, input logic r);
		@(posedge clk_i);
		master_irq_pins_i <= m;
		slave_irq_pins_i <= s;
		timer_zero_output_i <= t;
		rtc_irq_i <= r;
	endtask
	task automatic init(input logic [7:0] ev, input logic [7:0] b, input logic [7:0] w3,
		input logic [7:0] w4);
		wr(ev, 8'h11);
		wr(ev | 8'h01, b);
		wr(ev | 8'h01, w3);
		wr(ev | 8'h01, w4);
	endtask
	// waits for every announced vector, bounded so a lost acknowledge ends the run
	task automatic drain;
		int i;
		for (i = 0; i < 300 && vq.size() != 0; i++) @(posedge clk_i);
		if (vq.size() != 0) begin
			err_count++;
			end_of_test;
		end
		repeat (2) @(posedge clk_i);
	endtask
	task automatic quiet;
		repeat (4) @(posedge clk_i);
		check({7'h00, cpu_irq_out_o}, 8'h00);
	endtask
	always @(posedge clk_i) begin
		rd_pend <= rd_stb_i;
		if (rd_pend) check(rd_data_o, rq.size() != 0 ? rq.pop_front() : 8'hXX);
		if (vec_valid) check(vec, vq.size() != 0 ? vq.pop_front() : 8'hXX);
	end
	// ------
	// main sequence
	// ------
	initial begin
		void'($urandom(32'hFD33175B));
		{addr_i, wr_data_i, wr_stb_i, rd_stb_i, spur, slow} = '0;
		{master_irq_pins_i, slave_irq_pins_i, timer_zero_output_i, rtc_irq_i} = '0;
		reset_n_i = 1'b0;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		bm = 8'($urandom) & 8'hF8;
		bs = 8'($urandom) & 8'hF8;
		slow <= 1'($urandom);
		rd(8'h21, 8'h00);
		rd(8'h20, 8'h00);
		rd(8'($urandom) | 8'h40, 8'h00);
		init(8'h20, bm, 8'h04, 8'h01);
		init(8'hA0, bs, 8'h02, 8'h01);
		vq.push_back(bm | 8'h03);
		pins(8'h28, 8'h00, 1'b0, 1'b0);
		drain;
		quiet;
		wr(8'h20, 8'h0B);
		rd(8'h20, 8'h08);
		vq.push_back(bm | 8'h05);
		wr(8'h20, 8'h20);
		drain;
		wr(8'h20, 8'h65);
		rd(8'h20, 8'h00);
		vq.push_back(bm | 8'h06);
		pins(8'h40, 8'h00, 1'b0, 1'b0);
		drain;
		wr(8'h20, 8'h68);
		wr(8'h21, 8'h40);
		wr(8'h20, 8'h20);
		rd(8'h20, 8'h40);
		wr(8'h20, 8'h66);
		wr(8'h20, 8'h48);
		wr(8'h21, 8'h02);
		pins(8'h02, 8'h00, 1'b0, 1'b0);
		quiet;
		rd(8'h21, 8'h02);
		vq.push_back(bm | 8'h01);
		wr(8'h21, 8'h00);
		drain;
		wr(8'h20, 8'h20);
		vq.push_back(bm);
		pins(8'h00, 8'h00, 1'b1, 1'b1);
		drain;
		vq.push_back(bs);
		wr(8'h20, 8'h20);
		drain;
		wr(8'hA0, 8'h20);
		wr(8'h20, 8'h20);
		vq.push_back(bs | 8'h07);
		pins(8'h00, 8'h80, 1'b0, 1'b0);
		drain;
		wr(8'hA0, 8'h20);
		wr(8'h20, 8'h20);
		vq.push_back(bm | 8'h07);
		@(posedge clk_i);
		spur <= 1'b1;
		@(posedge clk_i);
		spur <= 1'b0;
		drain;
		wr(8'h21, 8'h80);
		init(8'h20, bm, 8'h04, 8'h03);
		rd(8'h21, 8'h00);
		wr(8'h21, 8'h80);
		pins(8'h80, 8'h00, 1'b0, 1'b0);
		rd(8'h20, 8'h80);
		vq.push_back(bm | 8'h04);
		pins(8'h90, 8'h00, 1'b0, 1'b0);
		drain;
		wr(8'h20, 8'h0B);
		rd(8'h20, 8'h00);
		repeat (3) @(posedge clk_i);
		end_of_test;
	end
endmodule // testbench
bind cic_top cic_props props (.clk_i, .reset_n_i, .addr_i, .rd_stb_i, .rd_data_o,
	.timer_zero_output_i, .rtc_irq_i, .master_irq_pins_i, .slave_irq_pins_i,
	.irq_ack_cycle_i, .cpu_irq_out_o, .peripheral_data_bus_o, .peripheral_data_oe_n_o);
`default_nettype wire
